// ==== hdl/asp_port.sv ====
// serial port pin control: chip select, serial clock, serial data,
// logic output pins and result coding; pins are sampled by core_clk_i
`timescale 1ns/1ps
module asp_port
  import asp_pkg::*;
#(
  parameter int unsigned FILL_N = FILL_COUNT,
  parameter int unsigned RES_W  = RESULT_W
) (
// What this block does
// - serial clock ignored while select high
// - serial output floats while deselected
// - bits move only on serial clock
// - logic pins from setup or config bits
// - zero drives negative rail, one positive
// - guard drive replaces first logic pin
// - select bit one means unipolar coding
// - bipolar mid-scale flips ones to zeros
// - fifteen fill then end byte resync
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             cs_n_i,
  input  wire logic             sclk_i,
  input  wire logic             serial_in_i,
  input  wire logic [1:0]       setup_logic_out_bits_i,
  input  wire logic [1:0]       cfg_logic_out_bits_i,
  input  wire logic             logic_out_source_sel_i,
  input  wire logic             guard_drive_enable_i,
  input  wire logic             unipolar_sel_i,
  input  wire logic [RES_W-1:0] raw_result_i,
  input  wire logic             tx_load_i,
  input  wire logic [7:0]       tx_byte_i,
  output logic                  serial_out_o,
  output logic                  serial_out_oe_o,
  output logic [1:0]            logic_out_pins_o,
  output logic                  guard_drive_o,
  output logic [RES_W-1:0]      coded_result_o,
  output logic [7:0]            rx_byte_o,
  output logic                  rx_valid_o,
  output logic                  port_resync_o,
  output logic                  cmd_mode_o
);
  logic [2:0]      pins_s;
  logic            cs_n_s, sclk_s, sdi_s;
  logic            sclk_d_r;
  logic            rise, fall;
  logic [2:0]      bit_cnt_r;
  logic [7:0]      shift_r;
  logic [7:0]      tx_r;
  logic [4:0]      fill_cnt_r;
  logic [7:0]      byte_nxt;
  asp_mode_e       mode_r;

  asp_sync #(.W(3)) u_sync (
    .clk_i   (core_clk_i),
    .reset_i (reset_i),
    .async_i ({cs_n_i, sclk_i, serial_in_i}),
    .sync_o  (pins_s)
  );
  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign sdi_s  = pins_s[0];

  always_ff @(posedge core_clk_i) begin
    if (reset_i) sclk_d_r <= 1'b0;
    else         sclk_d_r <= sclk_s;
  end
  assign rise = sclk_s & ~sclk_d_r & ~cs_n_s;
  assign fall = ~sclk_s & sclk_d_r & ~cs_n_s;
  assign byte_nxt = {shift_r[6:0], sdi_s};

  always_ff @(posedge core_clk_i) begin
    if (reset_i || cs_n_s) begin
      bit_cnt_r  <= 3'h0;
      shift_r    <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_byte_o  <= 8'h00;
    end else begin
      rx_valid_o <= 1'b0;
      if (rise) begin
        shift_r   <= byte_nxt;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'(BYTE_BITS - 1)) begin
          rx_byte_o  <= byte_nxt;
          rx_valid_o <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      fill_cnt_r    <= 5'h00;
      port_resync_o <= 1'b0;
      mode_r        <= ASP_CMD;
    end else begin
      port_resync_o <= 1'b0;
      if (tx_load_i) mode_r <= ASP_DATA;
      if (rx_valid_o) begin
        if (rx_byte_o == FILL_BYTE) begin
          if (fill_cnt_r < 5'(FILL_N)) fill_cnt_r <= fill_cnt_r + 5'h01;
        end else begin
          fill_cnt_r <= 5'h00;
          if (rx_byte_o == END_BYTE && fill_cnt_r >= 5'(FILL_N)) begin
            port_resync_o <= 1'b1;
            mode_r        <= ASP_CMD;
          end
        end
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) cmd_mode_o <= 1'b1;
    else         cmd_mode_o <= (mode_r == ASP_CMD);
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tx_r         <= 8'h00;
      serial_out_o <= 1'b0;
    end else if (tx_load_i) begin
      tx_r         <= tx_byte_i;
      serial_out_o <= tx_byte_i[7];
    end else if (fall) begin
      tx_r         <= {tx_r[6:0], 1'b0};
      serial_out_o <= tx_r[6];
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) serial_out_oe_o <= 1'b0;
    else         serial_out_oe_o <= ~cs_n_s;
  end

  // zero low rail, one high rail
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      logic_out_pins_o <= LOGIC_RESET;
      guard_drive_o    <= 1'b0;
    end else begin
      logic_out_pins_o <= logic_out_source_sel_i ? cfg_logic_out_bits_i
                                                 : setup_logic_out_bits_i;
      guard_drive_o    <= guard_drive_enable_i;
      if (guard_drive_enable_i) logic_out_pins_o[0] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) coded_result_o <= '0;
    else if (unipolar_sel_i) coded_result_o <= raw_result_i;
    else coded_result_o <= {~raw_result_i[RES_W-1], raw_result_i[RES_W-2:0]};
  end

  property p_float;
    @(posedge core_clk_i) disable iff (reset_i)
      cs_n_s |=> !serial_out_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("sdo driven idle");
  property p_ignore;
    @(posedge core_clk_i) disable iff (reset_i)
      cs_n_s |=> (bit_cnt_r == 3'h0) && !rx_valid_o;
  endproperty
  a_ignore: assert property (p_ignore) else $error("clock seen idle");
  property p_src;
    @(posedge core_clk_i) disable iff (reset_i)
      !guard_drive_enable_i |=> logic_out_pins_o == (
        $past(logic_out_source_sel_i) ? $past(cfg_logic_out_bits_i)
                                      : $past(setup_logic_out_bits_i));
  endproperty
  a_src: assert property (p_src) else $error("logic pins wrong");
  property p_guard;
    @(posedge core_clk_i) disable iff (reset_i)
      guard_drive_enable_i |=> guard_drive_o && !logic_out_pins_o[0];
  endproperty
  a_guard: assert property (p_guard) else $error("guard not driven");
  property p_uni;
    @(posedge core_clk_i) disable iff (reset_i)
      unipolar_sel_i |=> coded_result_o == $past(raw_result_i);
  endproperty
  a_uni: assert property (p_uni) else $error("unipolar coding wrong");
  property p_bip;
    @(posedge core_clk_i) disable iff (reset_i)
      !unipolar_sel_i |=>
        coded_result_o[RES_W-1] != $past(raw_result_i[RES_W-1]);
  endproperty
  a_bip: assert property (p_bip) else $error("bipolar coding wrong");
  property p_resync;
    @(posedge core_clk_i) disable iff (reset_i)
      port_resync_o |=> cmd_mode_o;
  endproperty
  a_resync: assert property (p_resync) else $error("no command mode");
  property p_rx;
    @(posedge core_clk_i) disable iff (reset_i)
      rx_valid_o |-> $past(rise);
  endproperty
  a_rx: assert property (p_rx) else $error("byte without edge");
  property p_shift;
    @(posedge core_clk_i) disable iff (reset_i)
      (fall && !tx_load_i) |=> serial_out_o == $past(tx_r[6]);
  endproperty
  a_shift: assert property (p_shift) else $error("sdo not shifted");
  property p_drive;
    @(posedge core_clk_i) disable iff (reset_i)
      !cs_n_s |=> serial_out_oe_o;
  endproperty
  a_drive: assert property (p_drive) else $error("sdo not driven");
  property p_fill;
    @(posedge core_clk_i) disable iff (reset_i)
      port_resync_o |-> $past(rx_valid_o && (rx_byte_o == END_BYTE)
                              && (fill_cnt_r >= 5'(FILL_N)));
  endproperty
  a_fill: assert property (p_fill) else $error("resync early");
  c_byte:   cover property (@(posedge core_clk_i) rx_valid_o);
  c_shift:  cover property (@(posedge core_clk_i) fall);
  c_bip:    cover property (@(posedge core_clk_i) !unipolar_sel_i);
  c_resync: cover property (@(posedge core_clk_i) port_resync_o);
  c_guard:  cover property (@(posedge core_clk_i) guard_drive_o);
endmodule : asp_port

// ==== hdl/asp_pkg.sv ====
// constants for the converter serial port pin control block
// assumes a single core clock domain; serial pins are asynchronous
package asp_pkg;
  localparam int unsigned FILL_COUNT    = 15;
  localparam logic [7:0]  FILL_BYTE     = 8'hff;
  localparam logic [7:0]  END_BYTE      = 8'hfe;
  localparam int unsigned BYTE_BITS     = 8;
  localparam logic [1:0]  SYNC_RESET    = 2'h3;
  localparam logic [1:0]  LOGIC_RESET   = 2'h0;
  localparam int unsigned RESULT_W      = 24;
  typedef enum logic [1:0] {ASP_CMD, ASP_DATA} asp_mode_e;
endpackage : asp_pkg

// ==== hdl/asp_sync.sv ====
// two flip-flop synchroniser, one per bit
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps
module asp_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          meta_r[g] <= 1'b1;
          sync_o[g] <= 1'b1;
        end else begin
          meta_r[g] <= async_i[g];
          sync_o[g] <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule : asp_sync

// ==== verif/asp_master.sv ====
// microcontroller model driving the converter serial port pins
// assumes callers start each task just after a core clock edge
`timescale 1ns/1ps
module asp_master (
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end
  task automatic sel(input logic on);
    #3 cs_n_o = ~on;
    if (!on) sdi_o = ~sdi_o;
    #80;
  endtask : sel
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi_o = tx[i];
      #80 sclk_o = 1'b1;
      rx[i] = sdo_i;
      #80 sclk_o = 1'b0;
    end
  endtask : xb
endmodule : asp_master

// ==== verif/adc_serial_port_pin_control_tb_top.sv ====
// self-checking bench for the serial port pin control block
// assumes asp_master drives the pins at a 160 ns serial clock
`timescale 1ns/1ps
module adc_serial_port_pin_control_tb_top;
  import asp_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, src = 1'b0, gd = 1'b0, uni = 1'b0;
  logic        ld = 1'b0, cs_n, sclk, serial_in, so, so_oe, vld, rs, cmd, gdo;
  logic [1:0]  stb = 2'h0, cfb = 2'h0, pins;
  logic [7:0]  txb = 8'h00, rxb, got, b, t, last_rx = 8'h00;
  logic [23:0] raw = 24'h000000, cod;
  int          n_errors = 0, total_checks = 0, n_vld = 0, n_rs = 0, v;
  wire         sdo_w = (so_oe === 1'b1) ? so : ~so;
  asp_port dut (.core_clk_i(clk), .reset_i(rst), .cs_n_i(cs_n),
    .sclk_i(sclk), .serial_in_i(serial_in), .setup_logic_out_bits_i(stb),
    .cfg_logic_out_bits_i(cfb), .logic_out_source_sel_i(src),
    .guard_drive_enable_i(gd), .unipolar_sel_i(uni), .raw_result_i(raw),
    .tx_load_i(ld), .tx_byte_i(txb), .serial_out_o(so),
    .serial_out_oe_o(so_oe), .logic_out_pins_o(pins), .guard_drive_o(gdo),
    .coded_result_o(cod), .rx_byte_o(rxb), .rx_valid_o(vld),
    .port_resync_o(rs), .cmd_mode_o(cmd));
  asp_master u_m (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(serial_in), .sdo_i(sdo_w));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    if (vld === 1'b1) begin
      n_vld   <= n_vld + 1;
      last_rx <= rxb;
    end
    if (rs === 1'b1) n_rs <= n_rs + 1;
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // one-cycle load pulse for the byte shifted out next
  task automatic load(input logic [7:0] d);
    @(posedge clk);
    txb <= d;
    ld  <= 1'b1;
    @(posedge clk);
    ld  <= 1'b0;
  endtask : load
  function automatic logic [2:0] exp_pin(logic s, g, logic [1:0] a, c);
    logic [1:0] p;
    p = s ? c : a;
    return g ? {1'b1, p[1], 1'b0} : {1'b0, p};
  endfunction : exp_pin
  // watchdog: run needs about 51 us of serial traffic
  initial begin
    #400us;
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(57));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("cmd_mode", 1, cmd);
    chk("sdo_oe", 0, so_oe);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      {src, gd, uni} <= i[2:0];
      {stb, cfb} <= 4'($urandom());
      raw <= (i < 4) ? 24'(24'h7fffff + i[1]) : 24'($urandom());
      repeat (2) @(posedge clk);
      #1;
      chk("pins", exp_pin(src, gd, stb, cfb), {gdo, pins});
      chk("coded", uni ? raw : 24'(raw - 24'h800000), cod);
    end
    load(8'ha5);
    u_m.sel(1'b1);
    chk("sdo_oe_sel", 1, so_oe);
    u_m.xb(8'h3c, got);
    u_m.sel(1'b0);
    chk("sdo_byte", 8'ha5, got);
    chk("rx_byte", 8'h3c, last_rx);
    chk("sdo_oe_desel", 0, so_oe);
    chk("cmd_data", 0, cmd);
    v = n_vld;
    u_m.xb(8'h55, got);
    chk("rx_count_desel", v, n_vld);
    repeat (4) begin
      b = 8'($urandom());
      t = 8'($urandom());
      load(t);
      u_m.sel(1'b1);
      u_m.xb(b, got);
      u_m.sel(1'b0);
      chk("rx_rand", b, last_rx);
      chk("sdo_rand", t, got);
    end
    for (int k = 14; k <= 15; k++) begin
      u_m.sel(1'b1);
      // non-fill byte first so no earlier fill run carries over
      u_m.xb(8'h00, got);
      repeat (k) u_m.xb(FILL_BYTE, got);
      u_m.xb(END_BYTE, got);
      u_m.sel(1'b0);
      chk("resync_count", k - 14, n_rs);
      chk("cmd_resync", k == 15, cmd);
    end
    end_of_test();
  end
endmodule : adc_serial_port_pin_control_tb_top
